// >>> logic/clr_pkg.sv
// package: register map, field layouts, reset values and carriers of the charger limit registers
// Functional notes
// - 20 mOhm sense: limit field bits 12..2, 4mA per lsb, others unused.
// - 10 mOhm sense: same field, 8mA per lsb, top at 12160mA.
// - limit writes keep field bits only and clamp at code 10111110000.
// - adapter power-on reset loads primary limit from the preset pin value.
// - secondary reset to 1.5A unless battery came first, then keeps value.
// - both limit registers read back their stored content.
// - secondary limit masks and clamps exactly like the primary.
// - duration register written by word command 38, only valid bits stored.
// - bits 2:0 pick primary level duration, 10/20/15/5/1/0.5/0.1/0 ms.
// - bits 10:8 pick secondary duration, 10us default through 10ms.
// - voltage ceiling word command 15, field bits 13..3, 8mV step.
// - voltage writes keep valid bits and clamp at code 11011000000.
// - ceiling is charge limit and bus target when battery absent or idle.
package clr_pkg;
  // ****************
  // command codes
  // ****************
  localparam logic [7:0] CMD_VOLT_CEIL = 8'h15;
  localparam logic [7:0] CMD_DURATIONS = 8'h38;
  localparam logic [7:0] CMD_LIM_SEC = 8'h3B;
  localparam logic [7:0] CMD_LIM_PRI = 8'h3F;
  // ****************
  // field layouts
  // ****************
  localparam int LIM_LSB = 2;
  localparam int LIM_W = 11;
  localparam logic [10:0] LIM_MAX = 11'h5F0;
  localparam int VOLT_LSB = 3;
  localparam int VOLT_W = 11;
  localparam logic [10:0] VOLT_MAX = 11'h6C0;
  localparam int DUR1_LSB = 0;
  localparam int DUR2_LSB = 8;
  localparam int DUR_W = 3;
  // ****************
  // reset values
  // ****************
  // the preset pin only loads on adapter power-on, so a plain reset starts from zero
  localparam logic [10:0] LIM_PRI_RST = 11'h000;
  // 1.5A at 4mA per lsb is 375 codes
  localparam logic [10:0] LIM_SEC_RST = 11'h177;
  localparam logic [15:0] DUR_RST = 16'h0000;
  localparam logic [10:0] VOLT_RST = 11'h000;
  typedef enum logic [2:0] {
    PRI_10MS, PRI_20MS, PRI_15MS, PRI_5MS, PRI_1MS, PRI_500US, PRI_100US, PRI_0MS
  } clr_pri_dur_t;
  typedef enum logic [2:0] {
    SEC_10US, SEC_100US, SEC_500US, SEC_1MS, SEC_300US, SEC_750US, SEC_2MS, SEC_10MS
  } clr_sec_dur_t;
  // word access from the host link
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] cmd;
    logic [15:0] data;
  } clr_req_t;
  typedef struct packed {
    logic [10:0] lim_pri;
    logic [10:0] lim_sec;
    clr_pri_dur_t dur_pri;
    clr_sec_dur_t dur_sec;
    logic [10:0] volt_ceil;
  } clr_cfg_t;
endpackage

// >>> logic/clr_field.sv
// leaf: mask a written word to its field and clamp to the field maximum
`timescale 1ns/1ps
`default_nettype none
module clr_field #(
  parameter int LSB = 2,
  parameter int W = 11,
  parameter logic [10:0] MAXV = 11'h5F0
) (
  // raw word
  input wire logic [15:0] word,
  // clamped field
  output logic [W-1:0] field
);
  logic [W-1:0] raw;
  assign raw = word[LSB +: W];
  assign field = (raw > MAXV[W-1:0]) ? MAXV[W-1:0] : raw;
endmodule
`default_nettype wire

// >>> logic/clr_regs.sv
// top: charger limit register bank behind the word access port
`timescale 1ns/1ps
`default_nettype none
module clr_regs import clr_pkg::*; (
  // clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // word access from the bus engine
  input wire clr_req_t req,
  output logic [15:0] rd_data,
  output logic rd_valid,
  // system status
  input wire logic adapter_por,
  input wire logic [10:0] limit_preset_pin,
  input wire logic batt_first,
  input wire logic batt_present,
  input wire logic charging,
  // values to the analog loops
  output clr_cfg_t cfg,
  output logic [10:0] full_charge_limit,
  output logic [10:0] bus_reg_target,
  output logic bus_reg_active
);
  // ****************
  // decode helpers
  // ****************
  // one selector feeds both the write and the read path, so the two never disagree on a code
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_LIM_PRI,
    SEL_LIM_SEC,
    SEL_DURATIONS,
    SEL_VOLT_CEIL
  } clr_sel_t;

  function automatic clr_sel_t decode_cmd(input logic [7:0] c);
    case (c)
      CMD_LIM_PRI: return SEL_LIM_PRI;
      CMD_LIM_SEC: return SEL_LIM_SEC;
      CMD_DURATIONS: return SEL_DURATIONS;
      CMD_VOLT_CEIL: return SEL_VOLT_CEIL;
      default: return SEL_NONE;
    endcase
  endfunction

  // limit channel 0 answers the primary code, channel 1 the secondary
  function automatic clr_sel_t lim_chan_sel(input int ch);
    return (ch == 0) ? SEL_LIM_PRI : SEL_LIM_SEC;
  endfunction

  clr_sel_t wr_sel;
  clr_sel_t rd_sel;
  always_comb begin
    wr_sel = req.wr ? decode_cmd(req.cmd) : SEL_NONE;
    rd_sel = req.rd ? decode_cmd(req.cmd) : SEL_NONE;
  end

  // ****************
  // adapter limit channels
  // ****************
  localparam int LIM_CH = 2;
  logic [LIM_W-1:0] lim_preset;
  logic [LIM_W-1:0] lim_q [LIM_CH];
  logic [LIM_CH-1:0] por_keep;
  logic [LIM_W-1:0] por_val [LIM_CH];

  // the preset code goes through the same clamp as a host write
  clr_field #(.LSB(LIM_LSB), .W(LIM_W), .MAXV(LIM_MAX)) u_preset (
    .word(16'(limit_preset_pin) << LIM_LSB),
    .field(lim_preset)
  );

  // what an adapter power-on reset does to each channel
  always_comb begin
    por_keep[0] = 1'b0;
    por_val[0] = lim_preset;
    por_keep[1] = batt_first;
    por_val[1] = LIM_SEC_RST;
  end

  for (genvar ch = 0; ch < LIM_CH; ch++) begin : g_lim
    logic [LIM_W-1:0] wr_val;
    logic [LIM_W-1:0] lim_ff, nxt_lim;
    // each channel has its own mask and clamp, identical by construction
    clr_field #(.LSB(LIM_LSB), .W(LIM_W), .MAXV(LIM_MAX)) u_lim (
      .word(req.data),
      .field(wr_val)
    );
    // adapter power-on reset wins over a same-cycle write, also when the value is kept
    always_comb begin
      nxt_lim = lim_ff;
      if (adapter_por) begin
        if (!por_keep[ch]) begin
          nxt_lim = por_val[ch];
        end
      end else if (wr_sel == lim_chan_sel(ch)) begin
        nxt_lim = wr_val;
      end
    end
    always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
        lim_ff <= (ch == 0) ? LIM_PRI_RST : LIM_SEC_RST;
      end else begin
        lim_ff <= nxt_lim;
      end
    end
    assign lim_q[ch] = lim_ff;
  end

  // ****************
  // level durations
  // ****************
  clr_pri_dur_t dur_pri_ff, nxt_dur_pri;
  clr_sec_dur_t dur_sec_ff, nxt_dur_sec;

  // bits outside the two code fields have no storage at all
  always_comb begin
    nxt_dur_pri = dur_pri_ff;
    nxt_dur_sec = dur_sec_ff;
    if (wr_sel == SEL_DURATIONS) begin
      nxt_dur_pri = clr_pri_dur_t'(req.data[DUR1_LSB +: DUR_W]);
      nxt_dur_sec = clr_sec_dur_t'(req.data[DUR2_LSB +: DUR_W]);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      dur_pri_ff <= clr_pri_dur_t'(DUR_RST[DUR1_LSB +: DUR_W]);
      dur_sec_ff <= clr_sec_dur_t'(DUR_RST[DUR2_LSB +: DUR_W]);
    end else begin
      dur_pri_ff <= nxt_dur_pri;
      dur_sec_ff <= nxt_dur_sec;
    end
  end

  // ****************
  // voltage ceiling
  // ****************
  logic [VOLT_W-1:0] volt_wr;
  logic [VOLT_W-1:0] volt_ff, nxt_volt;

  clr_field #(.LSB(VOLT_LSB), .W(VOLT_W), .MAXV(VOLT_MAX)) u_volt (
    .word(req.data),
    .field(volt_wr)
  );

  always_comb begin
    nxt_volt = volt_ff;
    if (wr_sel == SEL_VOLT_CEIL) begin
      nxt_volt = volt_wr;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      volt_ff <= VOLT_RST;
    end else begin
      volt_ff <= nxt_volt;
    end
  end

  // ****************
  // read path
  // ****************
  logic [15:0] rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;

  // read data holds between reads so a slow host can still pick it up
  always_comb begin
    nxt_rd_valid = req.rd;
    nxt_rd_data = rd_data_ff;
    if (req.rd) begin
      nxt_rd_data = 16'h0000;
      case (rd_sel)
        SEL_LIM_PRI: nxt_rd_data[LIM_LSB +: LIM_W] = lim_q[0];
        SEL_LIM_SEC: nxt_rd_data[LIM_LSB +: LIM_W] = lim_q[1];
        SEL_DURATIONS: begin
          nxt_rd_data[DUR1_LSB +: DUR_W] = dur_pri_ff;
          nxt_rd_data[DUR2_LSB +: DUR_W] = dur_sec_ff;
        end
        SEL_VOLT_CEIL: nxt_rd_data[VOLT_LSB +: VOLT_W] = volt_ff;
        default: nxt_rd_data = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
    end else begin
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  // ****************
  // values to the analog loops
  // ****************
  logic [VOLT_W-1:0] full_ff, nxt_full;
  logic [VOLT_W-1:0] tgt_ff, nxt_tgt;
  logic act_ff, nxt_act;

  // ceiling serves the charge limit always, the bus target when battery absent or not charging; one cycle behind cfg
  always_comb begin
    nxt_full = volt_ff;
    nxt_tgt = volt_ff;
    nxt_act = !batt_present || !charging;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      full_ff <= VOLT_RST;
      tgt_ff <= VOLT_RST;
      act_ff <= 1'b0;
    end else begin
      full_ff <= nxt_full;
      tgt_ff <= nxt_tgt;
      act_ff <= nxt_act;
    end
  end

  // ****************
  // outputs
  // ****************
  assign cfg = '{
    lim_pri: lim_q[0],
    lim_sec: lim_q[1],
    dur_pri: dur_pri_ff,
    dur_sec: dur_sec_ff,
    volt_ceil: volt_ff
  };
  assign rd_data = rd_data_ff;
  assign rd_valid = rd_valid_ff;
  assign full_charge_limit = full_ff;
  assign bus_reg_target = tgt_ff;
  assign bus_reg_active = act_ff;
endmodule
`default_nettype wire

// >>> bench/clr_host.sv
// partner: host issuing word writes and reads
`timescale 1ns/1ps
`default_nettype none
module clr_host import clr_pkg::*; (
  // answer
  input wire logic ref_clk,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  // request
  output var clr_req_t req
);
  initial req = '0;
  // strobe held to the next call, so words run back to back
  task automatic put(logic w, logic [7:0] c, logic [15:0] d, output logic [15:0] q);
    req = '{w, !w, c, d};
    @(posedge ref_clk);
    #1 q = rd_valid ? rd_data : 16'hXXXX;
  endtask
endmodule
`default_nettype wire

// >>> bench/clr_regs_chk.sv
// checker: cycle relations at the limit bank ports
`timescale 1ns/1ps
`default_nettype none
module clr_regs_chk import clr_pkg::*; (
  // watched ports
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire clr_req_t req,
  input wire logic rd_valid,
  input wire logic adapter_por,
  input wire logic [10:0] limit_preset_pin,
  input wire logic batt_first,
  input wire logic batt_present,
  input wire logic charging,
  input wire clr_cfg_t cfg,
  input wire logic [10:0] full_charge_limit,
  input wire logic [10:0] bus_reg_target,
  input wire logic bus_reg_active
);
  logic [10:0] lim_x, pin_x, volt_x;
  logic rest;
  always_comb begin
    lim_x = req.data[12:2] > LIM_MAX ? LIM_MAX : req.data[12:2];
    volt_x = req.data[13:3] > VOLT_MAX ? VOLT_MAX : req.data[13:3];
    pin_x = limit_preset_pin > LIM_MAX ? LIM_MAX : limit_preset_pin;
    rest = !batt_present || !charging;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  sequence s_wr(c);
    req.wr && req.cmd == c && !adapter_por;
  endsequence
  chk_rd_answer: assert property (req.rd |=> rd_valid) else $error("no read answer");
  chk_pri_write: assert property (s_wr(CMD_LIM_PRI) |=> cfg.lim_pri == $past(lim_x))
    else $error("primary limit");
  chk_sec_write: assert property (s_wr(CMD_LIM_SEC) |=> cfg.lim_sec == $past(lim_x))
    else $error("secondary limit");
  chk_por_preset: assert property (adapter_por |=> cfg.lim_pri == $past(pin_x)) else $error("preset");
  chk_por_keep: assert property (adapter_por && batt_first |=> $stable(cfg.lim_sec)) else $error("kept");
  chk_por_default: assert property (adapter_por && !batt_first |=> cfg.lim_sec == LIM_SEC_RST)
    else $error("default");
  chk_charge_copy: assert property ($past(rst_b) |-> full_charge_limit == $past(cfg.volt_ceil))
    else $error("charge limit");
  chk_bus_track: assert property ($past(rst_b) |-> bus_reg_active == $past(rest))
    else $error("bus active");
  chk_target_copy: assert property ($past(rst_b) |-> bus_reg_target == $past(cfg.volt_ceil))
    else $error("bus target");
  chk_volt_write: assert property (s_wr(CMD_VOLT_CEIL) |=> cfg.volt_ceil == $past(volt_x))
    else $error("voltage ceiling");
  chk_dur_write: assert property (s_wr(CMD_DURATIONS) |=>
    cfg.dur_pri == $past(req.data[2:0]) && cfg.dur_sec == $past(req.data[10:8])) else $error("durations");
  chk_rd_quiet: assert property (!req.rd |=> !rd_valid) else $error("stray read answer");
endmodule
bind clr_regs clr_regs_chk clr_regs_chk_i (.*);
`default_nettype wire

// >>> bench/clr_regs_tb.sv
// testbench: random and corner words into the limit bank
`timescale 1ns/1ps
`default_nettype none
module clr_regs_tb import clr_pkg::*; ;
  logic ref_clk = 0, rst_b = 0, adapter_por = 0, batt_first = 0, batt_present = 0, charging = 0;
  logic [10:0] limit_preset_pin = '0;
  logic [15:0] rd_data, q, d;
  logic rd_valid;
  clr_req_t req;
  int failures = 0, checked = 0;
  logic [7:0] cmds [5] = '{CMD_LIM_PRI, CMD_LIM_SEC, CMD_DURATIONS, CMD_VOLT_CEIL, 8'h39};
  always #20 ref_clk = ~ref_clk;
  clr_host clr_host_i (.ref_clk, .rd_data, .rd_valid, .req);
  clr_regs clr_regs_i (.ref_clk, .rst_b, .req, .rd_data, .rd_valid, .adapter_por, .limit_preset_pin, .batt_first,
    .batt_present, .charging, .cfg(), .full_charge_limit(), .bus_reg_target(), .bus_reg_active());
  function automatic logic [15:0] img(logic [7:0] k, logic [15:0] v);
    case (k)
      CMD_LIM_PRI, CMD_LIM_SEC: return {3'h0, v[12:2] > LIM_MAX ? LIM_MAX : v[12:2], 2'h0};
      CMD_VOLT_CEIL: return {2'h0, v[13:3] > VOLT_MAX ? VOLT_MAX : v[13:3], 3'h0};
      CMD_DURATIONS: return v & 16'h0707;
      default: return 16'h0000;
    endcase
  endfunction
  task automatic rd(logic [7:0] k, logic [15:0] e);
    clr_host_i.put(1'b0, k, 16'h0000, q);
    checked++;
    if (q !== e) begin
      failures++;
      $display("Error reg %h expected %h seen %h", k, e, q);
    end
  endtask
  task automatic summarize;
    $display("checked %0d failures %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h80982C41));
    repeat (2) @(posedge ref_clk);
    #1 rst_b = 1;
    rd(CMD_LIM_SEC, img(CMD_LIM_SEC, {3'h0, LIM_SEC_RST, 2'h0}));
    $display("reset done");
    for (int i = 0; i < 60; i++) begin
      d = i < 5 ? 16'hFFFF : 16'($urandom);
      // sweep every duration code in both fields
      if (i < 45)
        {d[10:8], d[2:0]} = {2{3'(i / 5 - 1)}};
      {batt_present, charging} = 2'($urandom);
      clr_host_i.put(1'b1, cmds[i % 5], d, q);
      rd(cmds[i % 5], img(cmds[i % 5], d));
    end
    $display("readback done");
    for (int b = 0; b < 2; b++) begin
      d = 16'($urandom);
      // write stays up into the power-on edge
      clr_host_i.put(1'b1, CMD_LIM_SEC, d, q);
      batt_first = b[0];
      limit_preset_pin = b ? 11'($urandom) : 11'h7FF;
      adapter_por = 1;
      @(posedge ref_clk);
      #1 adapter_por = 0;
      rd(CMD_LIM_PRI, img(CMD_LIM_PRI, {3'h0, limit_preset_pin, 2'h0}));
      rd(CMD_LIM_SEC, img(CMD_LIM_SEC, b ? d : {3'h0, LIM_SEC_RST, 2'h0}));
    end
    $display("power-on done");
    summarize();
  end
endmodule
`default_nettype wire
